// ===== hw/plrc_pkg.sv
// Shared constants for the loop reconfiguration scan port and its controller
package plrc_pkg;
    // Scan word layout
    localparam int CHAIN_LEN      = 62;
    localparam int FB_DIV_BIT     = 0;
    localparam int POST_DIV_LSB   = 1;
    localparam int POST_DIV_W     = 3;
    localparam int CH_DIV_LSB     = 4;   // Channel 0 lowest, channel 3 highest
    localparam int CH_DIV_W       = 8;
    localparam int NUM_CH         = 4;
    localparam int LOOP_DIV_LSB   = 36;
    localparam int REF_DIV_LSB    = 44;
    localparam int DIV_W          = 8;
    localparam int VCO_RANGE_LSB  = 53;
    localparam int VCO_RANGE_W    = 2;
    localparam int PUMP_FINE_LSB  = 55;
    localparam int PUMP_FINE_W    = 3;
    localparam int PUMP_CRS_LSB   = 58;
    localparam int PUMP_CRS_W     = 2;
    localparam int FILT_LSB       = 60;
    localparam int FILT_W         = 2;
    // Reset values of the active configuration
    localparam logic [2:0] POST_DIV_RST  = 3'h0;
    localparam logic [2:0] PUMP_FINE_RST = 3'h4;
    localparam logic [1:0] FILT_RST      = 2'h2;
    localparam logic [CHAIN_LEN-1:0] CFG_RST =
        {FILT_RST, 2'h0, PUMP_FINE_RST, 2'h0, 53'h0};
    // Delay line and output delay
    localparam int DELAY_CELLS    = 32;
    localparam int TAP_W          = 5;
    localparam int FINE_TAPS      = 8;
    localparam int COARSE_W       = 8;
    // Cycles the done flag stays high while counters reload
    localparam int APPLY_CYCLES   = 4;
endpackage

// ===== hw/plrc_if.sv
// Reconfiguration scan port joining the controller and the loop control
`timescale 1ns/100ps
interface plrc_if;
    logic reconfig_shift_clock;
    logic reconfig_shift_enable;
    logic reconfig_serial_in;
    logic reconfig_commit;
    logic reconfig_serial_out;
    logic reconfig_done;
    logic loop_async_reset;

    modport dev (
        input  reconfig_shift_clock, reconfig_shift_enable, reconfig_serial_in,
        input  reconfig_commit, loop_async_reset,
        output reconfig_serial_out, reconfig_done
    );
    modport ctl (
        output reconfig_shift_clock, reconfig_shift_enable, reconfig_serial_in,
        output reconfig_commit, loop_async_reset,
        input  reconfig_serial_out, reconfig_done
    );
endinterface

// ===== hw/plrc_ctrl.sv
// Fabric-side controller that shifts a configuration word and commits it
`timescale 1ns/100ps
module plrc_ctrl #(
    parameter int CLK_DIV = 4
) (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_n_i,
    // User side
    input  wire logic                              start_i,
    input  wire logic [plrc_pkg::CHAIN_LEN-1:0]    word_i,
    input  wire logic                              reset_loop_i,
    output logic                                   busy_o,
    // Scan port
    plrc_if.ctl                                    port
);
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_SHIFT  = 5'b00010,
        ST_COMMIT = 5'b00100,
        ST_WAIT   = 5'b01000,
        ST_RST    = 5'b10000
    } plrc_ctl_e;

    plrc_ctl_e                      state;
    logic [plrc_pkg::CHAIN_LEN-1:0] sreg;
    logic [6:0]                     bits;
    logic [7:0]                     div;
    logic                           sclk;
    logic                           do_rst;
    logic                           seen_done;
    logic                           fall;

    // Shift clock is a divided copy of clk_i; data changes on its falling edge
    assign fall = sclk && (div == 8'(CLK_DIV - 1));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // Shift clock keeps running so the scan side sees reset too
            div <= 8'h00;
            if (sclk) begin
                sclk <= 1'b0;
            end else begin
                sclk <= 1'b1;
            end
        end else if (div == 8'(CLK_DIV - 1)) begin
            div  <= 8'h00;
            sclk <= ~sclk;
        end else begin
            div <= div + 8'h01;
        end
    end

    // Sequence: enable with first bit, shift MSB first, then drop enable and raise commit on the same edge
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state     <= ST_IDLE;
            sreg      <= '0;
            bits      <= 7'h00;
            do_rst    <= 1'b0;
            seen_done <= 1'b0;
            port.reconfig_shift_enable <= 1'b0;
            port.reconfig_serial_in    <= 1'b0;
            port.reconfig_commit       <= 1'b0;
            port.loop_async_reset      <= 1'b0;
            busy_o    <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    port.loop_async_reset <= 1'b0;
                    if (start_i && fall) begin
                        sreg   <= word_i << 1;
                        do_rst <= reset_loop_i;
                        port.reconfig_serial_in    <= word_i[plrc_pkg::CHAIN_LEN-1];
                        port.reconfig_shift_enable <= 1'b1;
                        bits   <= 7'(plrc_pkg::CHAIN_LEN - 1);
                        busy_o <= 1'b1;
                        state  <= ST_SHIFT;
                    end
                end
                ST_SHIFT: if (fall) begin
                    if (bits == 7'h00) begin
                        port.reconfig_shift_enable <= 1'b0;
                        port.reconfig_commit       <= 1'b1;
                        state <= ST_COMMIT;
                    end else begin
                        port.reconfig_serial_in <= sreg[plrc_pkg::CHAIN_LEN-1];
                        sreg <= sreg << 1;
                        bits <= bits - 7'h01;
                    end
                end
                ST_COMMIT: if (fall) begin
                    port.reconfig_commit <= 1'b0;
                    seen_done <= 1'b0;
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (port.reconfig_done) begin
                        seen_done <= 1'b1;
                    end else if (seen_done) begin
                        port.loop_async_reset <= do_rst;
                        state <= do_rst ? ST_RST : ST_IDLE;
                        busy_o <= do_rst;
                    end
                end
                ST_RST: if (fall) begin
                    port.loop_async_reset <= 1'b0;
                    busy_o <= 1'b0;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign port.reconfig_shift_clock = sclk;
endmodule

// ===== hw/plrc_loop_ctl.sv
// Loop digital control: scan chain, commit, output gating and delay settings
`timescale 1ns/100ps
module plrc_loop_ctl #(
    parameter int LOCK_NS = 100000
) (
    // Clock and reset (clk_i clocks lock, outputs and delay; the scan chain runs on the shift clock)
    input  wire logic                              clk_i,
    input  wire logic                              rst_n_i,
    // Reference and loop clocks as sampled levels
    input  wire logic                              ref_clk_i,
    input  wire logic [plrc_pkg::FINE_TAPS-1:0]    vco_phase_i,
    // Mode controls
    input  wire logic                              bypass_i,
    input  wire logic                              power_up_i,
    input  wire logic [plrc_pkg::TAP_W-1:0]        phase_tap_count_i,
    input  wire logic [1:0]                        delay_cell_step_i,
    input  wire logic [2:0]                        fine_sel_i [plrc_pkg::NUM_CH],
    input  wire logic [plrc_pkg::COARSE_W-1:0]     coarse_dly_i [plrc_pkg::NUM_CH],
    // Outputs
    output logic [plrc_pkg::NUM_CH-1:0]            clk_out_o,
    output logic                                   locked_o,
    output logic [plrc_pkg::CHAIN_LEN-1:0]         config_o,
    output logic [7:0]                             phase_delay_steps_o,
    // Scan port
    plrc_if.dev                                    port
);
    localparam int CLK_NS   = 10;
    localparam int LOCK_CYC = (LOCK_NS + CLK_NS - 1) / CLK_NS;

    logic [plrc_pkg::CHAIN_LEN-1:0] chain;
    logic [plrc_pkg::CHAIN_LEN-1:0] cfg;
    logic [2:0]                     apply_cnt;
    logic                           done;
    logic [31:0]                    lock_cnt;
    logic                           lock_clear;
    logic [7:0]                     taps_plus_one;
    logic [plrc_pkg::NUM_CH-1:0]    started;
    logic [plrc_pkg::COARSE_W-1:0]  hold_cnt [plrc_pkg::NUM_CH];
    logic [plrc_pkg::NUM_CH-1:0]    next_out;
    logic [2:0]                     post_sel;
    logic                           post_clk;

    // Scan chain shifts MSB first and holds while enable is low
    always_ff @(posedge port.reconfig_shift_clock) begin
        if (!rst_n_i) begin
            chain <= '0;
        end else if (port.reconfig_shift_enable) begin
            chain <= {chain[plrc_pkg::CHAIN_LEN-2:0], port.reconfig_serial_in};
        end
    end

    // Chain head is always visible on the serial output
    assign port.reconfig_serial_out = chain[plrc_pkg::CHAIN_LEN-1];

    // Commit copies the chain into the active configuration
    always_ff @(posedge port.reconfig_shift_clock) begin
        if (!rst_n_i) begin
            cfg <= plrc_pkg::CFG_RST;
        end else if (port.reconfig_commit) begin
            cfg <= chain;
        end
    end

    // Apply window counter, loaded by commit
    always_ff @(posedge port.reconfig_shift_clock) begin
        if (!rst_n_i) begin
            apply_cnt <= 3'h0;
        end else if (port.reconfig_commit) begin
            apply_cnt <= 3'(plrc_pkg::APPLY_CYCLES);
        end else if (apply_cnt != 3'h0) begin
            apply_cnt <= apply_cnt - 3'h1;
        end
    end

    // Done rises with commit and falls as the window closes
    always_ff @(posedge port.reconfig_shift_clock) begin
        if (!rst_n_i) begin
            done <= 1'b0;
        end else if (port.reconfig_commit) begin
            done <= 1'b1;
        end else if (apply_cnt != 3'h0) begin
            done <= (apply_cnt != 3'h1);
        end
    end

    // Done flag towards the controller
    assign port.reconfig_done = done;
    // Field map: bit 0, 3:1, 35:4, 43:36, 51:44
    assign config_o = cfg;

    // Programmed taps plus the fixed cell
    assign taps_plus_one = {3'h0, phase_tap_count_i} + 8'h01;

    // Phase line delay in mux steps: step times tap count plus fixed cell
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            phase_delay_steps_o <= 8'h00;
        end else begin
            phase_delay_steps_o <= 8'({6'h00, delay_cell_step_i} * taps_plus_one);
        end
    end

    // Lock timer restarts on power-down or loop reset
    assign lock_clear = !rst_n_i || !power_up_i || port.loop_async_reset;

    always_ff @(posedge clk_i) begin
        if (lock_clear) begin
            lock_cnt <= 32'h0;
        end else if (lock_cnt != 32'(LOCK_CYC)) begin
            lock_cnt <= lock_cnt + 32'h1;
        end
    end

    // Lock flag rises once the timer has run out
    always_ff @(posedge clk_i) begin
        if (lock_clear) begin
            locked_o <= 1'b0;
        end else if (lock_cnt == 32'(LOCK_CYC)) begin
            locked_o <= 1'b1;
        end
    end

    // Output post divider tap: code 1xx div16; 0xx codes leave the output at div1, so the 010 and 011 taps go unused
    assign post_sel = cfg[plrc_pkg::POST_DIV_LSB +: plrc_pkg::POST_DIV_W];
    always_comb begin
        case (post_sel)
            3'h2: begin
                post_clk = vco_phase_i[3];
            end
            3'h3: begin
                post_clk = vco_phase_i[5];
            end
            3'h4, 3'h5, 3'h6, 3'h7: begin
                post_clk = vco_phase_i[7];
            end
            default: begin
                post_clk = vco_phase_i[0];
            end
        endcase
    end

    // Per channel: coarse hold-off count then fine phase tap
    genvar g;
    generate
        for (g = 0; g < plrc_pkg::NUM_CH; g++) begin : g_ch
            logic fine_clk;

            // Fine phase tap chosen for this channel
            assign fine_clk = vco_phase_i[fine_sel_i[g]];

            // Channel start flag, set once the hold-off has run out
            always_ff @(posedge clk_i) begin
                if (!rst_n_i || !power_up_i || !locked_o) begin
                    started[g] <= 1'b0;
                end else if (hold_cnt[g] == 8'h00) begin
                    started[g] <= 1'b1;
                end
            end

            // Coarse hold-off counter, reloaded while the loop is not locked
            always_ff @(posedge clk_i) begin
                if (!rst_n_i || !power_up_i || !locked_o) begin
                    hold_cnt[g] <= coarse_dly_i[g];
                end else if (!started[g] && hold_cnt[g] != 8'h00) begin
                    hold_cnt[g] <= hold_cnt[g] - 8'h01;
                end
            end

            // Output level: power-down, bypass or gated fine tap
            always_comb begin
                next_out[g] = 1'b0;
                if (!power_up_i) begin
                    next_out[g] = 1'b0;
                end else if (bypass_i) begin
                    next_out[g] = ref_clk_i;
                end else if (started[g]) begin
                    next_out[g] = fine_clk & (post_clk | ~post_sel[2]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            clk_out_o <= '0;
        end else begin
            clk_out_o <= next_out;
        end
    end
endmodule

// ===== verification/plrc_props.sv
// Checker for the reconfiguration scan port between the two ends
`timescale 1ns/100ps
module plrc_props (
    // Reset and scan port
    input wire logic rst_n_i,
    input wire logic reconfig_shift_clock,
    input wire logic reconfig_shift_enable,
    input wire logic reconfig_serial_in,
    input wire logic reconfig_commit,
    input wire logic reconfig_serial_out,
    input wire logic reconfig_done
);
    logic [61:0] shadow;
    logic [6:0]  seen;
    logic [6:0]  burst;

    default clocking cb @(posedge reconfig_shift_clock);
    endclocking
    default disable iff (!rst_n_i);

    // Copy of the chain, bits seen since reset and bits in this burst
    always_ff @(posedge reconfig_shift_clock) begin
        if (!rst_n_i) begin
            shadow <= 62'h0;
            seen   <= 7'h00;
            burst  <= 7'h00;
        end else begin
            if (reconfig_shift_enable) begin
                shadow <= {shadow[60:0], reconfig_serial_in};
            end
            if (reconfig_shift_enable && seen != 7'h3e) begin
                seen <= seen + 7'h01;
            end
            if (reconfig_commit) begin
                burst <= 7'h00;
            end else if (reconfig_shift_enable) begin
                burst <= burst + 7'h01;
            end
        end
    end

    property p_sout_msb;
        seen == 7'h3e |-> reconfig_serial_out == shadow[61];
    endproperty
    a_sout_msb: assert property (p_sout_msb)
        else $error("serial out is not the chain head");
    property p_sout_hold;
        !reconfig_shift_enable |=> $stable(reconfig_serial_out);
    endproperty
    a_sout_hold: assert property (p_sout_hold)
        else $error("chain moved while shifting was off");
    property p_burst_len;
        reconfig_commit |-> burst == 7'h3e;
    endproperty
    a_burst_len: assert property (p_burst_len)
        else $error("commit after a burst of wrong length");
    property p_commit_one;
        reconfig_commit |=> !reconfig_commit;
    endproperty
    a_commit_one: assert property (p_commit_one)
        else $error("commit longer than one period");
    property p_commit_idle;
        reconfig_commit |-> !reconfig_shift_enable;
    endproperty
    a_commit_idle: assert property (p_commit_idle)
        else $error("commit while still shifting");
    property p_done_start;
        reconfig_commit && !reconfig_done |=> reconfig_done;
    endproperty
    a_done_start: assert property (p_done_start)
        else $error("done did not rise after commit");
    property p_done_len;
        $rose(reconfig_done) |-> reconfig_done[*4] ##1 !reconfig_done;
    endproperty
    a_done_len: assert property (p_done_len)
        else $error("done high for the wrong time");
    property p_done_cause;
        $rose(reconfig_done) |-> $past(reconfig_commit);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("done rose without a commit");
endmodule

// ===== verification/tb.sv
// Self-checking bench joining the controller and the loop control
`timescale 1ns/100ps
module tb;
    logic        clk_i;
    logic        rst_n_i;
    logic        start_i;
    logic [61:0] word_i;
    logic        reset_loop_i;
    logic        busy_o;
    logic        ref_clk_i;
    logic [7:0]  vco_phase_i;
    logic        bypass_i;
    logic        power_up_i;
    logic [4:0]  phase_tap_count_i;
    logic [1:0]  delay_cell_step_i;
    logic [2:0]  fine_sel_i [plrc_pkg::NUM_CH];
    logic [7:0]  coarse_dly_i [plrc_pkg::NUM_CH];
    logic [3:0]  clk_out_o;
    logic        locked_o;
    logic [61:0] config_o;
    logic [7:0]  phase_delay_steps_o;
    int          failures;
    int          check_count;

    plrc_if port_if ();
    plrc_ctrl #(.CLK_DIV(1)) u_plrc_ctrl (.clk_i, .rst_n_i, .start_i, .word_i,
        .reset_loop_i, .busy_o, .port(port_if));
    plrc_loop_ctl #(.LOCK_NS(50)) u_plrc_loop_ctl (.clk_i, .rst_n_i, .ref_clk_i,
        .vco_phase_i, .bypass_i, .power_up_i, .phase_tap_count_i, .delay_cell_step_i,
        .fine_sel_i, .coarse_dly_i, .clk_out_o, .locked_o, .config_o,
        .phase_delay_steps_o, .port(port_if));
    plrc_props u_plrc_props (.rst_n_i,
        .reconfig_shift_clock(port_if.reconfig_shift_clock),
        .reconfig_shift_enable(port_if.reconfig_shift_enable),
        .reconfig_serial_in(port_if.reconfig_serial_in),
        .reconfig_commit(port_if.reconfig_commit),
        .reconfig_serial_out(port_if.reconfig_serial_out),
        .reconfig_done(port_if.reconfig_done));

    // Clock at 100 MHz
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 2000 && busy_o !== lvl; i++) cyc(1);
        if (busy_o !== lvl) begin
            failures++;
            end_sim();
        end
    endtask
    // Shift a word, check the old setting holds mid-shift, then the new one
    task automatic load(input logic [61:0] w, input logic [61:0] prev, input logic rl);
        word_i = w;
        reset_loop_i = rl;
        start_i = 1'b1;
        wait_busy(1'b1);
        start_i = 1'b0;
        cyc(20);
        chk("config_mid", {2'h0, prev}, {2'h0, config_o});
        wait_busy(1'b0);
        chk("config_new", {2'h0, w}, {2'h0, config_o});
    endtask
    // Every code of the 1-, 2- and 3-bit fields, loaded back to back
    task automatic t_fields();
        logic [61:0] w;
        logic [61:0] prev;
        prev = plrc_pkg::CFG_RST;
        for (int i = 0; i < 8; i++) begin
            w = 62'h0;
            w[plrc_pkg::FB_DIV_BIT] = i[0];
            w[plrc_pkg::POST_DIV_LSB +: 3] = i[2:0];
            for (int c = 0; c < 4; c++) w[plrc_pkg::CH_DIV_LSB + 8 * c +: 8] = 8'(i * 37 + c);
            w[plrc_pkg::LOOP_DIV_LSB +: 8] = (i == 7) ? 8'hff : 8'(i);
            w[plrc_pkg::REF_DIV_LSB +: 8] = 8'(8'hf0 + i);
            w[plrc_pkg::VCO_RANGE_LSB +: 2] = i[1:0];
            w[plrc_pkg::PUMP_FINE_LSB +: 3] = i[2:0];
            w[plrc_pkg::PUMP_CRS_LSB +: 2] = i[2:1];
            w[plrc_pkg::FILT_LSB +: 2] = ~i[1:0];
            load(w, prev, i[0]);
            prev = w;
        end
    endtask
    // Power-down, lock wait and bypass
    task automatic t_modes();
        for (int i = 0; i < 4; i++) begin
            ref_clk_i = ~ref_clk_i;
            vco_phase_i = ~vco_phase_i;
            cyc(1);
            chk("out_pd", 64'h0, 64'(clk_out_o));
        end
        power_up_i = 1'b1;
        cyc(1);
        chk("lock_early", 64'h0, 64'(locked_o));
        for (int i = 0; i < 200 && locked_o !== 1'b1; i++) cyc(1);
        chk("lock_late", 64'h1, 64'(locked_o));
        bypass_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            ref_clk_i = ~ref_clk_i;
            cyc(2);
            chk("out_byp", {60'h0, {4{ref_clk_i}}}, 64'(clk_out_o));
        end
        bypass_i = 1'b0;
        vco_phase_i = 8'h08;
        cyc(2);
        chk("out_fine", 64'h2, 64'(clk_out_o));
        vco_phase_i = 8'h01;
        cyc(2);
        chk("out_hold", 64'h0, 64'(clk_out_o));
        cyc(260);
        chk("out_start", 64'h1, 64'(clk_out_o));
    endtask
    // Phase line length at both ends of the tap range, with steps 1 to 3
    task automatic t_delay();
        for (int i = 0; i < 3; i++) begin
            phase_tap_count_i = (i == 0) ? 5'h1f : 5'(i * 15 - 15);
            delay_cell_step_i = (i == 0) ? 2'h3 : 2'(i);
            cyc(2);
            chk("delay", 64'(delay_cell_step_i * (phase_tap_count_i + 1)),
                64'(phase_delay_steps_o));
        end
    endtask

    // Reset, then each scenario in turn
    initial begin
        failures = 0;
        check_count = 0;
        {rst_n_i, start_i, word_i, reset_loop_i, ref_clk_i, bypass_i, power_up_i} = '0;
        {vco_phase_i, phase_tap_count_i, delay_cell_step_i} = 15'h0f01;
        for (int c = 0; c < 4; c++) begin
            fine_sel_i[c] = 3'(c * 3);
            coarse_dly_i[c] = (c == 0) ? 8'hff : 8'(c);
        end
        cyc(8);
        rst_n_i = 1'b1;
        cyc(1);
        chk("config_rst", {2'h0, plrc_pkg::CFG_RST}, {2'h0, config_o});
        t_modes();
        t_delay();
        t_fields();
        end_sim();
    end
endmodule
